/* File: verilog/atb_cfg.svh */
// constants for the address tenure arbitration block
`ifndef ATB_CFG_SVH
`define ATB_CFG_SVH
// address phase field widths
`define ATB_ADDR_W 32
`define ATB_AP_W 4
`define ATB_BYTE_W 8
`define ATB_TT_W 5
`define ATB_TSIZ_W 3
// level of an active-low line at rest and after reset
`define ATB_NEGATED 1'h1
`define ATB_ASSERTED 1'h0
// clocks from transfer start to address acknowledge (least 1)
`define ATB_ADDR_ACK_N_DELAY 1
// width of the acknowledge delay counter
`define ATB_CNT_W 8
`endif

/* File: verilog/atb_pkg.sv */
// types shared by both ends of the address tenure link
`default_nettype none
package atb_pkg;
	// address tenure states of the bus master
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REQ,
		ST_TENURE,
		ST_GAP
	} atb_mst_state_t;
	// owner of the address bus grant
	typedef enum logic {
		OWN_DEV,
		OWN_OTHER
	} atb_owner_t;
endpackage : atb_pkg
`default_nettype wire

/* File: verilog/atb_bus_if.sv */
// address bus wires shared by the processor end and the arbiter end
`default_nettype none
`include "atb_cfg.svh"
interface atb_bus_if;
	// processor end drive values and enables
	logic bus_request_n;
	logic addr_busy_n_o;
	logic addr_busy_oe;
	logic transfer_start_n_o;
	logic addr_oe;
	logic [`ATB_ADDR_W-1:0] addr_o;
	logic [`ATB_AP_W-1:0] addr_parity_o;
	logic [`ATB_TT_W-1:0] transfer_type_o;
	logic [`ATB_TSIZ_W-1:0] transfer_size_o;
	logic burst_flag_n_o;
	logic cache_inhibit_n_o;
	logic write_through_n_o;
	logic global_snoop_n_o;
	// other masters on the bus, driven by the bench
	logic x_addr_busy_n;
	logic x_transfer_start_n;
	logic x_addr_oe;
	logic [`ATB_ADDR_W-1:0] x_addr;
	logic [`ATB_AP_W-1:0] x_addr_parity;
	logic x_global_snoop_n;
	// arbiter and slave answers
	logic bus_grant_n;
	logic addr_ack_n;
	logic addr_retry_n;
	// resolved bus: busy and start pulled up, wired low; address, parity and global picked by addr_oe
	logic addr_busy_n;
	logic transfer_start_n;
	logic [`ATB_ADDR_W-1:0] addr;
	logic [`ATB_AP_W-1:0] addr_parity;
	logic global_snoop_n;
	assign addr_busy_n = (addr_busy_oe ? addr_busy_n_o : `ATB_NEGATED) & x_addr_busy_n;
	assign transfer_start_n = (addr_oe ? transfer_start_n_o : `ATB_NEGATED) & x_transfer_start_n;
	assign addr = addr_oe ? addr_o : x_addr;
	assign addr_parity = addr_oe ? addr_parity_o : x_addr_parity;
	assign global_snoop_n = addr_oe ? global_snoop_n_o : x_global_snoop_n;
	// processor end
	modport dev (
		output bus_request_n, addr_busy_n_o, addr_busy_oe, transfer_start_n_o, addr_oe,
		output addr_o, addr_parity_o, transfer_type_o, transfer_size_o, burst_flag_n_o,
		output cache_inhibit_n_o, write_through_n_o, global_snoop_n_o,
		input bus_grant_n, addr_ack_n, addr_retry_n, addr_busy_n, transfer_start_n,
		input addr, addr_parity, global_snoop_n
	);
	// arbiter and slave end
	modport arb (
		output bus_grant_n, addr_ack_n, addr_retry_n,
		input bus_request_n, addr_busy_n, transfer_start_n
	);
endinterface : atb_bus_if
`default_nettype wire

/* File: verilog/atb_master.sv */
// processor end of the address tenure: request, grant, transfer, parity
// Behaviour
// - request held until grant and bus free
// - grant qualified: grant, not busy, no retry
// - qualified grant: busy on, request off, start
// - arbiter grants at most one master
// - grant may be held permanently asserted
// - parked grant launches one edge after need
// - busy released a clock after acknowledge
// - withdrawn request never drives busy
// - request held at least one clock
// - busy is pin OR rebuilt local busy
// - no qualified grant during any start
// - busy wire optional only when safe
// - every start acknowledged while awake
// - start marks address and attributes valid
// - snooped start with or after busy tracked
// - acknowledge no earlier than clock after start
// - 32 address, 4 parity, 5 type, 3 size
// - master drives odd parity per byte
// - snoop start plus global compares parity
// - mismatch raises machine check when enabled
// - checkstop when machine check disabled
// - arbiter parks on most recent master
// - arbitration lines active low, pulled negated
`default_nettype none
`include "atb_cfg.svh"
module atb_master #(
	parameter int ADDR_W = `ATB_ADDR_W,
	parameter int AP_W = `ATB_AP_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// bus side
	atb_bus_if.dev bus,
	// transaction request from the core
	input wire logic need_bus,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [`ATB_TT_W-1:0] req_type,
	input wire logic [`ATB_TSIZ_W-1:0] req_size,
	input wire logic req_burst,
	input wire logic req_inhibit,
	input wire logic req_wthru,
	input wire logic req_global,
	// progress back to the core
	output logic req_taken,
	output logic tenure_done,
	output logic is_master,
	// parity error control and reporting
	input wire logic addr_parity_check_en,
	input wire logic machine_check_enable,
	output logic machine_check,
	output logic checkstop
);
	// odd parity of one byte
	function automatic logic odd_bit(input logic [`ATB_BYTE_W-1:0] b);
		odd_bit = ~(^b);
	endfunction : odd_bit

	// odd parity per address byte, bit i covers byte i
	function automatic logic [AP_W-1:0] odd_par(input logic [ADDR_W-1:0] a);
		logic [AP_W-1:0] p;
		p = '0;
		for (int i = 0; i < AP_W; i++) begin
			p[i] = odd_bit(a[i*`ATB_BYTE_W +: `ATB_BYTE_W]);
		end
		odd_par = p;
	endfunction : odd_par

	atb_pkg::atb_mst_state_t state_reg; // tenure state
	atb_pkg::atb_mst_state_t state_next; // next tenure state
	logic local_busy_reg; // rebuilt busy from start and acknowledge
	logic local_busy_next; // next rebuilt busy
	logic own_reg; // we are address bus master
	logic ts_reg; // start pulse being driven this cycle
	logic br_n_reg; // request line, low when asserted
	logic [ADDR_W-1:0] addr_reg; // captured address
	logic [AP_W-1:0] ap_reg; // parity of captured address
	logic [`ATB_TT_W-1:0] tt_reg; // captured type
	logic [`ATB_TSIZ_W-1:0] tsiz_reg; // captured size
	logic [3:0] attr_reg; // burst, inhibit, write-through, global
	logic done_reg; // acknowledge taken
	logic mc_reg; // machine check pulse
	logic cs_reg; // sticky checkstop

	// decoded bus events
	wire ts_seen; // some master is starting a transfer
	wire addr_ack_n_seen; // acknowledge on the bus
	wire busy; // bus taken by anyone
	wire qual; // qualified grant
	wire launch; // start our tenure at this edge
	wire ack_ok; // acknowledge usable for our tenure
	wire snoop; // snooped global transfer
	wire par_err; // enabled parity mismatch

	assign ts_seen = (bus.transfer_start_n == `ATB_ASSERTED);
	assign addr_ack_n_seen = (bus.addr_ack_n == `ATB_ASSERTED);
	// pin busy or the rebuilt busy, either one blocks
	assign busy = (bus.addr_busy_n == `ATB_ASSERTED) | local_busy_reg;
	// grant alone is not enough: bus idle, no retry, no start
	assign qual = (bus.bus_grant_n == `ATB_ASSERTED) & ~busy
		& (bus.addr_retry_n == `ATB_NEGATED)
		& ~ts_seen;
	// parked or requesting, a qualified grant with need launches
	assign launch = need_bus & qual
		& ((state_reg == atb_pkg::ST_IDLE) | (state_reg == atb_pkg::ST_REQ));
	// acknowledge in the start cycle itself is too early
	assign ack_ok = addr_ack_n_seen & ~ts_reg;
	// snoop: not master, start and global together
	assign snoop = ~own_reg & ts_seen & (bus.global_snoop_n == `ATB_ASSERTED);
	assign par_err = snoop & (bus.addr_parity != odd_par(bus.addr))
		& addr_parity_check_en;

	// rebuilt busy: set by a start, cleared by acknowledge, which wins over a start in the same cycle
	always_comb begin
		local_busy_next = local_busy_reg;
		if (addr_ack_n_seen) begin
			local_busy_next = 1'h0; // tenure ends
		end else if (ts_seen) begin
			local_busy_next = 1'h1; // start with or after busy
		end
	end

	// tenure sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			atb_pkg::ST_IDLE: begin
				if (launch) begin
					state_next = atb_pkg::ST_TENURE; // parked, no request cycle
				end else if (need_bus) begin
					state_next = atb_pkg::ST_REQ; // not parked, ask
				end
			end
			atb_pkg::ST_REQ: begin
				if (!need_bus) begin
					state_next = atb_pkg::ST_IDLE; // withdrawn, no busy
				end else if (launch) begin
					state_next = atb_pkg::ST_TENURE; // take mastership
				end
			end
			atb_pkg::ST_TENURE: begin
				if (ack_ok) begin
					state_next = atb_pkg::ST_GAP; // acknowledged
				end
			end
			atb_pkg::ST_GAP: begin
				state_next = atb_pkg::ST_IDLE; // busy negated one clock
			end
		endcase
	end

	// state and rebuilt busy registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= atb_pkg::ST_IDLE;
			local_busy_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			local_busy_reg <= local_busy_next;
		end
	end

	// arbitration outputs: request, busy, start
	always_ff @(posedge core_clk) begin
		if (srst) begin
			br_n_reg <= `ATB_NEGATED;
			own_reg <= 1'h0;
			ts_reg <= 1'h0;
		end else begin
			// request only in the request state, so at least one clock
			br_n_reg <= (state_next == atb_pkg::ST_REQ) ? `ATB_ASSERTED : `ATB_NEGATED;
			// busy held through the tenure, dropped in the gap
			own_reg <= (state_next == atb_pkg::ST_TENURE);
			// start with busy, for one clock
			ts_reg <= launch;
		end
	end

	// address and attributes captured at launch
	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr_reg <= '0;
			ap_reg <= '0;
			tt_reg <= '0;
			tsiz_reg <= '0;
			attr_reg <= '0;
		end else if (launch) begin
			addr_reg <= req_addr;
			ap_reg <= odd_par(req_addr);
			tt_reg <= req_type;
			tsiz_reg <= req_size;
			attr_reg <= {req_burst, req_inhibit, req_wthru, req_global};
		end
	end

	// core reporting and parity errors
	always_ff @(posedge core_clk) begin
		if (srst) begin
			done_reg <= 1'h0;
			mc_reg <= 1'h0;
			cs_reg <= 1'h0;
		end else begin
			done_reg <= (state_reg == atb_pkg::ST_TENURE) & ack_ok;
			mc_reg <= par_err & machine_check_enable;
			cs_reg <= cs_reg | (par_err & ~machine_check_enable);
		end
	end

	// bus drive: all arbitration lines active low
	assign bus.bus_request_n = br_n_reg;
	assign bus.addr_busy_n_o = ~own_reg;
	assign bus.addr_busy_oe = own_reg;
	assign bus.transfer_start_n_o = ~ts_reg;
	assign bus.addr_oe = own_reg; // address group valid with start
	assign bus.addr_o = addr_reg;
	assign bus.addr_parity_o = ap_reg;
	assign bus.transfer_type_o = tt_reg;
	assign bus.transfer_size_o = tsiz_reg;
	assign bus.burst_flag_n_o = ~attr_reg[3];
	assign bus.cache_inhibit_n_o = ~attr_reg[2];
	assign bus.write_through_n_o = ~attr_reg[1];
	assign bus.global_snoop_n_o = ~attr_reg[0];

	// core side outputs
	assign req_taken = ts_reg;
	assign tenure_done = done_reg;
	assign is_master = own_reg;
	assign machine_check = mc_reg;
	assign checkstop = cs_reg;
endmodule : atb_master
`default_nettype wire

/* File: verilog/atb_arbiter.sv */
// arbiter and address slave end: grants, parking, acknowledge, retry
`default_nettype none
`include "atb_cfg.svh"
module atb_arbiter #(
	parameter bit GRANT_HELD = 1'h0,
	parameter logic [`ATB_CNT_W-1:0] ADDR_ACK_N_DELAY = `ATB_CNT_W'(`ATB_ADDR_ACK_N_DELAY)
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// bus side
	atb_bus_if.arb bus,
	// second master on the bus
	input wire logic other_req,
	output logic other_grant,
	// slave controls
	input wire logic retry_req,
	input wire logic sleep
);
	atb_pkg::atb_owner_t owner_reg; // current grant owner
	atb_pkg::atb_owner_t owner_next; // next grant owner
	logic pend_reg; // start seen, acknowledge owed
	logic [`ATB_CNT_W-1:0] cnt_reg; // clocks left to acknowledge
	logic addr_retry_n_n_reg; // registered retry line

	wire ts_seen; // start on the bus
	wire dev_req; // processor requesting
	wire free; // no tenure in progress
	wire fire; // acknowledge this cycle
	wire first; // zero-based delay load

	assign ts_seen = (bus.transfer_start_n == `ATB_ASSERTED);
	assign dev_req = (bus.bus_request_n == `ATB_ASSERTED);
	assign free = (bus.addr_busy_n == `ATB_NEGATED) & ~pend_reg & ~ts_seen;
	// acknowledge at least one clock after start, not while asleep
	assign fire = pend_reg & (cnt_reg == '0) & ~sleep;
	assign first = (ADDR_ACK_N_DELAY == '0) ? 1'h0 : 1'h1;

	// grant choice: switch only when free, else park on last owner
	always_comb begin
		owner_next = owner_reg; // park on most recent master
		if (free) begin
			if (dev_req & other_req) begin
				// both asking: the one not served last
				owner_next = (owner_reg == atb_pkg::OWN_DEV) ? atb_pkg::OWN_OTHER
					: atb_pkg::OWN_DEV;
			end else if (dev_req) begin
				owner_next = atb_pkg::OWN_DEV;
			end else if (other_req) begin
				owner_next = atb_pkg::OWN_OTHER;
			end
		end
	end

	// owner register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			owner_reg <= atb_pkg::OWN_DEV;
		end else begin
			owner_reg <= owner_next;
		end
	end

	// acknowledge bookkeeping, every start answered once
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pend_reg <= 1'h0;
			cnt_reg <= '0;
		end else if (ts_seen) begin
			pend_reg <= 1'h1;
			cnt_reg <= ADDR_ACK_N_DELAY - `ATB_CNT_W'(first);
		end else if (fire) begin
			pend_reg <= 1'h0;
		end else if (pend_reg & (cnt_reg != '0)) begin
			cnt_reg <= cnt_reg - `ATB_CNT_W'(1);
		end
	end

	// retry line, registered
	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr_retry_n_n_reg <= `ATB_NEGATED;
		end else begin
			addr_retry_n_n_reg <= ~retry_req;
		end
	end

	// only one owner holds a grant held grant for a lone master
	assign bus.bus_grant_n = (GRANT_HELD | (owner_reg == atb_pkg::OWN_DEV))
		? `ATB_ASSERTED : `ATB_NEGATED;
	assign other_grant = ~GRANT_HELD & (owner_reg == atb_pkg::OWN_OTHER);
	assign bus.addr_ack_n = ~fire;
	assign bus.addr_retry_n = addr_retry_n_n_reg;
endmodule : atb_arbiter
`default_nettype wire

/* File: sim/atb_props.sv */
// assertions on the shared address tenure wires
`default_nettype none
`include "atb_cfg.svh"
module atb_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// arbitration and tenure wires
	input wire logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic addr_busy_n,
	input wire logic addr_busy_n_o,
	input wire logic addr_busy_oe,
	input wire logic transfer_start_n,
	input wire logic transfer_start_n_o,
	input wire logic addr_oe,
	input wire logic [`ATB_ADDR_W-1:0] addr_o,
	input wire logic [`ATB_AP_W-1:0] addr_parity_o,
	input wire logic addr_ack_n,
	input wire logic addr_retry_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// our own start cycle and our own busy drive
	wire logic go = addr_oe & ~transfer_start_n_o;
	wire logic mine = addr_busy_oe & ~addr_busy_n_o;
	property p_qual;
		go |-> $past(~bus_grant_n & addr_busy_n & addr_retry_n & transfer_start_n);
	endproperty
	a_qual: assert property (p_qual) else $error("launch on unqualified grant");
	property p_start_busy;
		go |-> mine && bus_request_n;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start without busy");
	property p_start_one;
		go |=> !go;
	endproperty
	a_start_one: assert property (p_start_one) else $error("start longer than a clock");
	property p_gap;
		(mine && !go && !addr_ack_n) |=> !mine;
	endproperty
	a_gap: assert property (p_gap) else $error("busy not released after ack");
	property p_parity;
		addr_oe |-> addr_parity_o == {~^addr_o[31:24], ~^addr_o[23:16], ~^addr_o[15:8], ~^addr_o[7:0]};
	endproperty
	a_parity: assert property (p_parity) else $error("bad address parity");
	// request stands only while we are not master, so it drops at our start
	property p_req_hold;
		!bus_request_n |-> !mine;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request during own tenure");
	property p_withdraw;
		($rose(bus_request_n) && !go) |-> !mine;
	endproperty
	a_withdraw: assert property (p_withdraw) else $error("busy on withdrawn request");
	property p_ack_late;
		!transfer_start_n |-> addr_ack_n;
	endproperty
	a_ack_late: assert property (p_ack_late) else $error("ack in start cycle");
	property p_ack_due;
		!transfer_start_n |-> ##[1:40] !addr_ack_n;
	endproperty
	a_ack_due: assert property (p_ack_due) else $error("start never acknowledged");
	property p_addr_hold;
		(addr_oe && $past(addr_oe)) |-> $stable(addr_o);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in tenure");
	// main scenarios
	c_go: cover property (go);
	c_withdraw: cover property ($rose(bus_request_n) && !go);
	c_snoop: cover property (!transfer_start_n && !addr_oe);
endmodule : atb_props
`default_nettype wire

/* File: sim/address_tenure_arbitration_tb.sv */
// self-checking bench joining the processor end and the arbiter end
`default_nettype none
`include "atb_cfg.svh"
module address_tenure_arbitration_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'h0;
	logic srst = 1'h1;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	// core side and slave controls
	logic need_bus = 1'h0;
	logic [31:0] req_addr = 32'h0;
	logic [4:0] req_type = 5'h0;
	logic [2:0] req_size = 3'h0;
	logic [3:0] req_flag = 4'h0;
	logic addr_parity_check_en = 1'h0;
	logic machine_check_enable = 1'h1;
	logic other_req = 1'h0;
	logic retry_req = 1'h0;
	logic sleep = 1'h0;
	logic req_taken, tenure_done, is_master, machine_check, checkstop, other_grant;
	logic cs_q = 1'h0;
	// expected launches and parity verdicts
	logic [43:0] tq[$];
	logic [1:0] eq[$];
	atb_bus_if bus ();
	atb_master u_atb_master (.core_clk(core_clk), .srst(srst), .bus(bus), .need_bus(need_bus),
		.req_addr(req_addr), .req_type(req_type), .req_size(req_size), .req_burst(req_flag[3]),
		.req_inhibit(req_flag[2]), .req_wthru(req_flag[1]), .req_global(req_flag[0]),
		.req_taken(req_taken), .tenure_done(tenure_done), .is_master(is_master),
		.addr_parity_check_en(addr_parity_check_en),
		.machine_check_enable(machine_check_enable), .machine_check(machine_check),
		.checkstop(checkstop));
	atb_arbiter u_atb_arbiter (.core_clk(core_clk), .srst(srst), .bus(bus),
		.other_req(other_req), .other_grant(other_grant), .retry_req(retry_req), .sleep(sleep));
	atb_props u_atb_props (.core_clk(core_clk), .srst(srst), .bus_request_n(bus.bus_request_n),
		.bus_grant_n(bus.bus_grant_n), .addr_busy_n(bus.addr_busy_n),
		.addr_busy_n_o(bus.addr_busy_n_o), .addr_busy_oe(bus.addr_busy_oe),
		.transfer_start_n(bus.transfer_start_n), .transfer_start_n_o(bus.transfer_start_n_o),
		.addr_oe(bus.addr_oe), .addr_o(bus.addr_o), .addr_parity_o(bus.addr_parity_o),
		.addr_ack_n(bus.addr_ack_n), .addr_retry_n(bus.addr_retry_n));
	always #25 core_clk = ~core_clk;
	task automatic chk(input logic ok);
		tests_run++;
		if (ok !== 1'h1) begin
			n_mismatch++;
			$display("[ERR] %0t unexpected result", $time);
		end
	endtask : chk
	task automatic complete_run();
		if (tq.size() != 0 || eq.size() != 0) n_mismatch++;
		if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// odd parity per byte, low byte in bit 0
	function automatic logic [3:0] odd_par(input logic [31:0] a);
		for (int i = 0; i < 4; i++) odd_par[i] = ~^a[8*i+:8];
	endfunction : odd_par
	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// result watcher: oldest note against what appears
	always @(posedge core_clk) begin
		if (req_taken === 1'h1) begin
			if (tq.size() == 0) chk(1'h0);
			else chk({bus.addr, bus.transfer_type_o, bus.transfer_size_o, bus.burst_flag_n_o,
				bus.cache_inhibit_n_o, bus.write_through_n_o, bus.global_snoop_n_o,
				bus.transfer_start_n, is_master} === {tq.pop_front(), 2'h1});
		end
		if (machine_check === 1'h1 || (checkstop === 1'h1 && !cs_q)) begin
			if (eq.size() == 0) chk(1'h0);
			else chk({machine_check, checkstop} === eq.pop_front());
		end
		cs_q <= checkstop;
	end
	// one tenure: lat>0 parked latency, 0 requested, <0 held off that long
	task automatic tenure(input int lat, input bit hold, input bit slp);
		logic [31:0] a;
		logic [4:0] t;
		logic [2:0] s;
		logic [3:0] f;
		int n;
		bit r;
		bit g;
		a = $urandom();
		t = 5'($urandom());
		s = 3'($urandom_range(4, 0));
		f = 4'($urandom());
		req_addr <= a;
		req_type <= t;
		req_size <= s;
		req_flag <= f;
		need_bus <= 1'h1;
		tq.push_back({a, t, s, ~f});
		n = 0;
		r = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (bus.bus_request_n === 1'h0) r = 1;
		end while (req_taken !== 1'h1 && n < 50);
		need_bus <= hold;
		g = (lat > 0) ? (n == lat && !r) : ((lat == 0) ? (n > 2 && r) : (n > -lat));
		chk(g && n < 50);
		if (slp) begin
			sleep <= 1'h1;
			repeat (6) @(posedge core_clk);
			sleep <= 1'h0;
		end
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (tenure_done !== 1'h1 && n < 50);
		chk(n < 50);
	endtask : tenure
	initial begin
		logic [3:0] cs [5];
		logic [31:0] a;
		bit r;
		bit k;
		// snoop cases: global, check enable, machine check enable, parity flip
		cs = '{4'hF, 4'hB, 4'hE, 4'h7, 4'hD};
		void'($urandom(41245));
		bus.x_addr_busy_n = 1'h1;
		bus.x_transfer_start_n = 1'h1;
		bus.x_addr_oe = 1'h0;
		bus.x_addr = 32'h0;
		bus.x_addr_parity = 4'h0;
		bus.x_global_snoop_n = 1'h1;
		repeat (10) @(posedge core_clk);
		srst <= 1'h0;
		@(posedge core_clk);
		for (int i = 0; i < 4; i++) tenure(2, i < 3, i == 1);
		retry_req <= 1'h1;
		repeat (2) @(posedge core_clk);
		fork
			tenure(-5, 0, 0);
			begin repeat (5) @(posedge core_clk); retry_req <= 1'h0; end
		join
		other_req <= 1'h1;
		repeat (4) @(posedge core_clk);
		chk(other_grant === 1'h1);
		tenure(0, 0, 0);
		repeat (4) @(posedge core_clk);
		need_bus <= 1'h1;
		@(posedge core_clk);
		need_bus <= 1'h0;
		r = 0;
		k = 0;
		repeat (10) begin
			@(posedge core_clk);
			r |= bus.bus_request_n === 1'h0;
			k |= req_taken === 1'h1;
		end
		chk(r && !k);
		other_req <= 1'h0;
		foreach (cs[i]) begin
			a = $urandom();
			addr_parity_check_en <= cs[i][2];
			machine_check_enable <= cs[i][1];
			bus.x_addr <= a;
			bus.x_addr_parity <= odd_par(a) ^ {3'h0, cs[i][0]};
			bus.x_global_snoop_n <= ~cs[i][3];
			bus.x_addr_busy_n <= 1'h0;
			if (cs[i][3] && cs[i][2] && cs[i][0]) eq.push_back({cs[i][1], ~cs[i][1]});
			// start a cycle after busy, or together with it in the checkstop case
			if (cs[i][1]) @(posedge core_clk);
			bus.x_transfer_start_n <= 1'h0;
			@(posedge core_clk);
			bus.x_transfer_start_n <= 1'h1;
			repeat (3) @(posedge core_clk);
			bus.x_addr_busy_n <= 1'h1;
			repeat (3) @(posedge core_clk);
		end
		complete_run();
	end
endmodule : address_tenure_arbitration_tb
`default_nettype wire
